// file: pwm_pkg.sv
// constants for the motor pwm time base, dead-time and fault core
package pwm_pkg;
    // register indices on the plain register port
    localparam logic [3:0]  ADDR_COUNTER  = 4'h0;
    localparam logic [3:0]  ADDR_PERIOD   = 4'h1;
    localparam logic [3:0]  ADDR_TRIGCMP  = 4'h2;
    localparam logic [3:0]  ADDR_PAIRCFG  = 4'h3;
    localparam logic [3:0]  ADDR_UPDCTL   = 4'h4;
    localparam logic [3:0]  ADDR_DTTIME   = 4'h5;
    localparam logic [3:0]  ADDR_DTSEL    = 4'h6;
    localparam logic [3:0]  ADDR_FAULTA   = 4'h7;
    localparam logic [3:0]  ADDR_OVERRIDE = 4'h8;
    localparam logic [3:0]  ADDR_DUTY0    = 4'h9;
    localparam logic [3:0]  ADDR_DUTY3    = 4'hc;

    // writable bits of the counter, period, pair config, update control, dead-time select and fault a registers
    localparam logic [15:0] MASK_COUNT    = 16'h7fff;
    localparam logic [15:0] MASK_PERIOD   = 16'h7fff;
    localparam logic [15:0] MASK_PAIRCFG  = 16'h0fff;
    localparam logic [15:0] MASK_UPDCTL   = 16'h0f07;
    localparam logic [15:0] MASK_DTSEL    = 16'h00ff;
    localparam logic [15:0] MASK_FAULTA   = 16'hff8f;

    // reset values
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] RST_PAIRCFG   = 16'h00ff;
    localparam logic [15:0] RST_OVERRIDE  = 16'hff00;

    // field positions
    localparam int          TRIG_DIR_BIT  = 15;
    localparam int          MODE_LSB      = 8;
    localparam int          EN_HIGH_LSB   = 4;
    localparam int          EN_LOW_LSB    = 0;
    localparam int          POST_LSB      = 8;
    localparam int          IUE_BIT       = 2;
    localparam int          OVERRIDE_SYNC_SELECT_BIT     = 1;
    localparam int          UPDATE_INHIBIT_BIT      = 0;
    localparam int          UNIT_B_LSB    = 8;
    localparam int          PS_LSB        = 6;
    localparam int          OVR_LSB       = 8;
    localparam int          FMODE_BIT     = 7;

    localparam int          NPAIR         = 4;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_e;
endpackage : pwm_pkg

// file: motor_pwm_core.sv
// motor pwm core: time base, trigger, pair modes, override, dead time, fault a
// Operation
// [R1] counter bit 15 reads direction, read-only
// [R2] 15-bit running count, software read/write
// [R3] 15-bit period, top bit reads zero
// [R4] trigger when compare equals running count
// [R5] trigger also needs matching direction bit
// [R6] 4-bit postscaler divides triggers 1:1 to 1:16
// [R7] per-pair mode: 1 independent, 0 complementary
// [R8] per-pin enables, reset from strap
// [R9] override sync to time base or cycle
// [R10] dead-time prescale codes give 1, 2, 4, 8 cycles
// [R11] dead time is 6-bit count of periods
// [R12] per-edge unit select: 1 unit B
// [R13] per-pair fault a enable
// [R14] fault drives override values, latched or cycle
// [R15] complementary low is complement of high
// [R16] fault a has priority over others
// [R17] duty update immediate or at boundary
// [R18] dead time only in complementary pairs
`timescale 1ns/1ps
`default_nettype none

module motor_pwm_core (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    // register port
    input  wire logic [3:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output wire logic [15:0]              reg_rdata,
    // strap and fault input
    input  wire logic                     pin_ownership_config,
    input  wire logic                     fault_a_n,
    // power stage
    output wire logic [pwm_pkg::NPAIR-1:0] pwm_high,
    output wire logic [pwm_pkg::NPAIR-1:0] pwm_low,
    output wire logic [pwm_pkg::NPAIR-1:0] high_output_enable,
    output wire logic [pwm_pkg::NPAIR-1:0] low_output_enable,
    output wire logic                     trigger_out
);
    import pwm_pkg::*;

    typedef struct packed {
        logic [14:0]        cnt;
        count_dir_e         dir;
        logic [15:0]        per;
        logic [15:0]        sec;
        logic [15:0]        cfg;
        logic [15:0]        upd;
        logic [15:0]        dtt;
        logic [15:0]        dts;
        logic [15:0]        flt;
        logic [15:0]        ovd;
        logic [15:0]        ovd_act;
        logic [3:0][15:0]   duty;
        logic [3:0][15:0]   act;
        logic [3:0]         pcnt;
        logic               trig;
        logic [3:0][8:0]    dtc;
        logic [3:0]         raw_q;
        logic [3:0]         flt_lat;
        logic [3:0]         pwm_h;
        logic [3:0]         pwm_l;
        logic               strap_done;
        logic [15:0]        rdata;
    } state_s;

    state_s               st_ff;
    state_s               nxt_st;
    logic                 fault_in;
    logic                 bnd;
    logic                 match;
    logic [3:0]           raw;
    logic [3:0]           fault_on;
    logic [3:0][8:0]      dt_pick;

    // dead-time length in cycles: count times 1, 2, 4 or 8
    function automatic logic [8:0] dt_cycles(input logic [1:0] ps, input logic [5:0] n);
        dt_cycles = {3'b000, n} << ps; // R10 R11
    endfunction : dt_cycles

    assign fault_in = ~fault_a_n;
    assign bnd      = (st_ff.dir == DIR_DOWN) && (st_ff.cnt == 15'h0000);
    assign match    = (st_ff.cnt == st_ff.sec[14:0]) // R4
                   && (st_ff.dir == count_dir_e'(st_ff.sec[TRIG_DIR_BIT])); // R5

    always_comb begin
        for (int i = 0; i < NPAIR; i++) begin
            raw[i]      = {1'b0, st_ff.cnt} < st_ff.act[i];
            fault_on[i] = st_ff.flt[i] && (fault_in || st_ff.flt_lat[i]); // R13
            // rising edge uses the active select, falling edge the inactive one
            if (raw[i] ? st_ff.dts[2*i+1] : st_ff.dts[2*i]) begin // R12
                dt_pick[i] = dt_cycles(st_ff.dtt[UNIT_B_LSB+PS_LSB +: 2],
                                       st_ff.dtt[UNIT_B_LSB +: 6]);
            end else begin
                dt_pick[i] = dt_cycles(st_ff.dtt[PS_LSB +: 2], st_ff.dtt[5:0]);
            end
        end
    end

    always_comb begin
        logic       gen_h;
        logic       gen_l;
        logic       comp;
        logic [1:0] di;
        gen_h  = 1'b0;
        gen_l  = 1'b0;
        comp   = 1'b0;
        di     = 2'b00;
        nxt_st = st_ff;

        // time base: continuous up/down between zero and period
        if (st_ff.dir == DIR_UP) begin
            if ({1'b0, st_ff.cnt} >= st_ff.per) begin
                nxt_st.dir = DIR_DOWN; // R1
            end else begin
                nxt_st.cnt = st_ff.cnt + 15'h0001;
            end
        end else begin
            if (st_ff.cnt == 15'h0000) begin
                nxt_st.dir = DIR_UP; // R1
            end else begin
                nxt_st.cnt = st_ff.cnt - 15'h0001;
            end
        end

        // special event trigger with postscaler
        nxt_st.trig = 1'b0;
        if (match) begin
            if (st_ff.pcnt >= st_ff.upd[POST_LSB +: 4]) begin // R6
                nxt_st.trig = 1'b1;
                nxt_st.pcnt = 4'h0;
            end else begin
                nxt_st.pcnt = st_ff.pcnt + 4'h1;
            end
        end

        // duty transfer to the active comparators
        if (!st_ff.upd[UPDATE_INHIBIT_BIT] && (st_ff.upd[IUE_BIT] || bnd)) begin
            nxt_st.act = st_ff.duty; // R17
        end

        // override transfer
        if (!st_ff.upd[OVERRIDE_SYNC_SELECT_BIT] || bnd) begin
            nxt_st.ovd_act = st_ff.ovd; // R9
        end

        // fault latch: the input wins over any clear
        for (int i = 0; i < NPAIR; i++) begin
            if (fault_in && st_ff.flt[i]) begin
                nxt_st.flt_lat[i] = 1'b1;
            end else if (st_ff.flt[FMODE_BIT] ? bnd
                         : (reg_wr && reg_addr == ADDR_FAULTA)) begin
                nxt_st.flt_lat[i] = 1'b0; // R14
            end
        end

        // pair outputs
        for (int i = 0; i < NPAIR; i++) begin
            comp = !st_ff.cfg[MODE_LSB+i]; // R7
            nxt_st.raw_q[i] = raw[i];
            if (comp && (raw[i] != st_ff.raw_q[i])) begin
                nxt_st.dtc[i] = dt_pick[i]; // R18
            end else if (st_ff.dtc[i] != 9'h000) begin
                nxt_st.dtc[i] = st_ff.dtc[i] - 9'h001; // R11
            end else begin
                nxt_st.dtc[i] = 9'h000;
            end
            if (comp) begin
                gen_h = raw[i] && (nxt_st.dtc[i] == 9'h000);
                gen_l = !raw[i] && (nxt_st.dtc[i] == 9'h000); // R15
            end else begin
                gen_h = raw[i];
                gen_l = raw[i];
            end
            // fault first, then manual override, then generator
            if (fault_on[i]) begin
                nxt_st.pwm_h[i] = st_ff.flt[OVR_LSB+2*i+1]; // R14 R16
                nxt_st.pwm_l[i] = st_ff.flt[OVR_LSB+2*i];
            end else begin
                nxt_st.pwm_h[i] = st_ff.ovd_act[OVR_LSB+2*i+1] ? gen_h
                                  : st_ff.ovd_act[2*i+1];
                nxt_st.pwm_l[i] = st_ff.ovd_act[OVR_LSB+2*i] ? gen_l
                                  : st_ff.ovd_act[2*i];
            end
        end

        // pin enables take the strap once after reset
        if (!st_ff.strap_done) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.cfg[7:0]   = {8{pin_ownership_config}}; // R8
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr == ADDR_COUNTER) begin
                nxt_st.cnt = reg_wdata[14:0]; // R2
            end else if (reg_addr == ADDR_PERIOD) begin
                nxt_st.per = reg_wdata & MASK_PERIOD; // R3
            end else if (reg_addr == ADDR_TRIGCMP) begin
                nxt_st.sec = reg_wdata;
            end else if (reg_addr == ADDR_PAIRCFG) begin
                nxt_st.cfg = reg_wdata & MASK_PAIRCFG;
            end else if (reg_addr == ADDR_UPDCTL) begin
                nxt_st.upd = reg_wdata & MASK_UPDCTL;
            end else if (reg_addr == ADDR_DTTIME) begin
                nxt_st.dtt = reg_wdata;
            end else if (reg_addr == ADDR_DTSEL) begin
                nxt_st.dts = reg_wdata & MASK_DTSEL;
            end else if (reg_addr == ADDR_FAULTA) begin
                nxt_st.flt = reg_wdata & MASK_FAULTA;
            end else if (reg_addr == ADDR_OVERRIDE) begin
                nxt_st.ovd = reg_wdata;
            end else if (reg_addr >= ADDR_DUTY0 && reg_addr <= ADDR_DUTY3) begin
                di = 2'(reg_addr - ADDR_DUTY0);
                nxt_st.duty[di] = reg_wdata;
            end
        end

        // register reads, data one cycle later
        nxt_st.rdata = RST_ZERO;
        if (reg_rd) begin
            if (reg_addr == ADDR_COUNTER) begin
                nxt_st.rdata = {st_ff.dir, st_ff.cnt & MASK_COUNT[14:0]}; // R1 R2
            end else if (reg_addr == ADDR_PERIOD) begin
                nxt_st.rdata = st_ff.per & MASK_PERIOD; // R3
            end else if (reg_addr == ADDR_TRIGCMP) begin
                nxt_st.rdata = st_ff.sec;
            end else if (reg_addr == ADDR_PAIRCFG) begin
                nxt_st.rdata = st_ff.cfg;
            end else if (reg_addr == ADDR_UPDCTL) begin
                nxt_st.rdata = st_ff.upd;
            end else if (reg_addr == ADDR_DTTIME) begin
                nxt_st.rdata = st_ff.dtt;
            end else if (reg_addr == ADDR_DTSEL) begin
                nxt_st.rdata = st_ff.dts;
            end else if (reg_addr == ADDR_FAULTA) begin
                nxt_st.rdata = st_ff.flt;
            end else if (reg_addr == ADDR_OVERRIDE) begin
                nxt_st.rdata = st_ff.ovd;
            end else if (reg_addr >= ADDR_DUTY0 && reg_addr <= ADDR_DUTY3) begin
                nxt_st.rdata = st_ff.duty[2'(reg_addr - ADDR_DUTY0)];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff         <= '0;
            st_ff.cfg     <= RST_PAIRCFG;
            st_ff.ovd     <= RST_OVERRIDE;
            st_ff.ovd_act <= RST_OVERRIDE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata          = st_ff.rdata;
    assign pwm_high           = st_ff.pwm_h;
    assign pwm_low            = st_ff.pwm_l;
    assign high_output_enable = st_ff.cfg[EN_HIGH_LSB +: 4];
    assign low_output_enable  = st_ff.cfg[EN_LOW_LSB +: 4];
    assign trigger_out        = st_ff.trig;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    count_read_a: assert property ( // R1 R2
        reg_rd && reg_addr == ADDR_COUNTER
        |=> reg_rdata == {$past(st_ff.dir), $past(st_ff.cnt)}
    ) else $error("counter read does not show direction and count");

    period_top_a: assert property ( // R3
        reg_rd && reg_addr == ADDR_PERIOD |=> reg_rdata[15] == 1'b0
    ) else $error("period top bit not zero");

    trig_cause_a: assert property ( // R4 R5
        $rose(trigger_out) |-> $past(match)
    ) else $error("trigger without compare and direction match");

    post_one_a: assert property ( // R6
        match && st_ff.upd[POST_LSB +: 4] == 4'h0 |=> trigger_out
    ) else $error("1:1 postscale missed a trigger");

    comp_excl_a: assert property ( // R15
        !$past(st_ff.cfg[MODE_LSB]) && !$past(fault_on[0])
        && $past(st_ff.ovd_act[OVR_LSB]) && $past(st_ff.ovd_act[OVR_LSB+1])
        |-> !(pwm_high[0] && pwm_low[0])
    ) else $error("complementary pair high and low both on");

    dt_load_a: assert property ( // R11 R12 R18
        !st_ff.cfg[MODE_LSB] && raw[0] != st_ff.raw_q[0] |=> st_ff.dtc[0] == $past(dt_pick[0])
    ) else $error("dead-time counter not loaded from selected unit");

    duty_imm_a: assert property ( // R17
        reg_wr && reg_addr == ADDR_DUTY0 && st_ff.upd[IUE_BIT] && !st_ff.upd[UPDATE_INHIBIT_BIT]
        ##1 st_ff.upd[IUE_BIT] && !st_ff.upd[UPDATE_INHIBIT_BIT]
        |=> st_ff.act[0] == $past(reg_wdata, 2)
    ) else $error("immediate duty update late");

    ovr_imm_a: assert property ( // R9
        reg_wr && reg_addr == ADDR_OVERRIDE && !st_ff.upd[OVERRIDE_SYNC_SELECT_BIT] ##1 !st_ff.upd[OVERRIDE_SYNC_SELECT_BIT]
        |=> st_ff.ovd_act == $past(reg_wdata, 2)
    ) else $error("unsynchronised override not applied");

    fault_drive_a: assert property ( // R13 R14
        fault_on[0] |=> pwm_high[0] == $past(st_ff.flt[OVR_LSB+1])
                     && pwm_low[0] == $past(st_ff.flt[OVR_LSB])
    ) else $error("fault did not force override values");

    rdata_idle_a: assert property ( // R2
        !reg_rd
        |=> reg_rdata == RST_ZERO
    ) else $error("read data not cleared after idle cycle");

    dir_turn_a: assert property ( // R1
        st_ff.dir == DIR_UP && {1'b0, st_ff.cnt} >= st_ff.per
        |=> st_ff.dir == DIR_DOWN
    ) else $error("time base did not turn down at period");

    per_store_a: assert property ( // R3
        reg_wr && reg_addr == ADDR_PERIOD
        |=> st_ff.per[15] == 1'b0
    ) else $error("period top bit stored");

    dt_count_a: assert property ( // R11
        st_ff.dtc[0] != 9'h000 && !(!st_ff.cfg[MODE_LSB] && raw[0] != st_ff.raw_q[0])
        |=> st_ff.dtc[0] == $past(st_ff.dtc[0]) - 9'h001
    ) else $error("dead-time counter did not count down");

    indep_no_dt_a: assert property ( // R18
        st_ff.cfg[MODE_LSB] && st_ff.dtc[0] == 9'h000
        |=> st_ff.dtc[0] == 9'h000
    ) else $error("dead time started on an independent pair");

    latch_hold_a: assert property ( // R14
        st_ff.flt_lat[0] && !st_ff.flt[FMODE_BIT] && !(reg_wr && reg_addr == ADDR_FAULTA)
        |=> st_ff.flt_lat[0]
    ) else $error("latched fault released without a write");

endmodule : motor_pwm_core

`default_nettype wire

// file: power_stage_model.sv
// power stage model: drives fault input a toward the core
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
    // clock
    input  wire logic mclk,
    // fault request from the bench
    input  wire logic fault_req,
    // fault line, idles high like a pulled-up driver fault pin
    output var  logic fault_a_n
);
    initial fault_a_n = 1'b1;

    // fault line changes just after a rising edge, active low
    always @(posedge mclk) begin
        fault_a_n <= ~fault_req;
    end
endmodule : power_stage_model

`default_nettype wire

// file: testbench.sv
// self-checking bench for the motor pwm core
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pwm_pkg::*;

    logic              mclk      = 1'b0;
    logic              reset_n   = 1'b0;
    logic [3:0]        reg_addr  = 4'h0;
    logic [15:0]       reg_wdata = 16'h0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic              strap     = 1'b0;
    logic              fault_req = 1'b0;
    wire  logic [15:0] reg_rdata;
    wire  logic        fault_a_n;
    wire  logic        trigger_out;
    wire  logic [3:0]  pwm_high;
    wire  logic [3:0]  pwm_low;
    wire  logic [3:0]  high_output_enable;
    wire  logic [3:0]  low_output_enable;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                n;
    int                g;
    logic [15:0]       rv;
    logic [15:0]       pv;
    logic              su;
    logic              sd;
    logic [15:0]       mask_tab [8] = '{16'h0, MASK_PERIOD, 16'hffff, MASK_PAIRCFG,
                                        MASK_UPDCTL, 16'hffff, MASK_DTSEL, MASK_FAULTA};
    logic [15:0]       dt_tab [3]   = '{16'hc243, 16'hc243, 16'h8504};
    logic [15:0]       sel_tab [3]  = '{16'h0002, 16'h0001, 16'h0002};
    int                ina_tab [3]  = '{6, 16, 4};
    int                act_tab [3]  = '{16, 6, 20};
    int                ps_tab [3]   = '{0, 2, 15};

    always #2.5 mclk = ~mclk;

    motor_pwm_core motor_pwm_core_i (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_ownership_config(strap), .fault_a_n(fault_a_n), .pwm_high(pwm_high),
        .pwm_low(pwm_low), .high_output_enable(high_output_enable),
        .low_output_enable(low_output_enable), .trigger_out(trigger_out));

    power_stage_model power_stage_model_i (
        .mclk(mclk), .fault_req(fault_req), .fault_a_n(fault_a_n));

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask : chk

    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rchk(input string w, input logic [3:0] a, input logic [15:0] e);
        rd(a, rv);
        chk(w, e, rv);
    endtask : rchk

    task automatic pins(input string w, input logic [1:0] e);
        chk(w, {14'h0, e}, {14'h0, pwm_high[0], pwm_low[0]});
    endtask : pins

    // cycles from one trigger pulse to the next
    task automatic wait_trig(output int k);
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (trigger_out !== 1'b1 && k < 3000);
        if (trigger_out !== 1'b1) chk("trigger wait", 16'h0, 16'h1);
    endtask : wait_trig

    // write at a known time-base phase; late changes wait for the boundary
    task automatic apply(input logic [3:0] a, input logic [15:0] d, input logic [1:0] e,
                         input logic late);
        int k;
        wait_trig(k);
        wr(a, d);
        k = 0;
        while ({pwm_high[0], pwm_low[0]} !== e && k < 200) begin
            cyc(1);
            k++;
        end
        chk("settle delay", {15'h0, late}, {15'h0, k >= 50});
        pins("pair0 pins", e);
    endtask : apply

    // length of the both-low gap after the lead pin falls
    task automatic gap_meas(input logic hi, output int k);
        k = 0;
        #1;
        while ((hi ? pwm_high[0] : pwm_low[0]) !== 1'b1 && k < 300) begin
            cyc(1);
            k++;
        end
        while ((hi ? pwm_high[0] : pwm_low[0]) !== 1'b0 && k < 300) begin
            cyc(1);
            k++;
        end
        if (k >= 300) chk("gap wait", 16'h0, 16'h1);
        k = 0;
        while (pwm_high[0] === 1'b0 && pwm_low[0] === 1'b0 && k < 300) begin
            cyc(1);
            k++;
        end
    endtask : gap_meas

    task automatic do_reset(input logic s);
        @(posedge mclk);
        strap <= s;
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        cyc(2);
    endtask : do_reset

    initial begin
        #200000;
        chk("watchdog", 16'h0, 16'h1);
        end_sim();
    end

    initial begin
        do_reset(1'b0);
        rchk("pair config", ADDR_PAIRCFG, 16'h0000);
        chk("enables", 16'h0, {8'h0, high_output_enable, low_output_enable});
        for (int a = 1; a < 8; a++) if (a != 3) rchk("reset value", 4'(a), RST_ZERO);
        rchk("override reset", ADDR_OVERRIDE, RST_OVERRIDE);
        for (int a = 1; a < 8; a++) wr(4'(a), 16'hffff);
        wr(4'hd, 16'hffff);
        for (int a = 1; a < 8; a++) rchk("masked", 4'(a), mask_tab[a]);
        rchk("unmapped", 4'hd, 16'h0000);
        do_reset(1'b1);
        rchk("pair config", ADDR_PAIRCFG, RST_PAIRCFG);
        chk("enables", 16'h00ff, {8'h0, high_output_enable, low_output_enable});
        wr(ADDR_PAIRCFG, 16'h0a5a);
        cyc(3);
        chk("enables", 16'h005a, {8'h0, high_output_enable, low_output_enable});
        wr(ADDR_PERIOD, 16'h0028);
        rd(ADDR_COUNTER, pv);
        su = 1'b0;
        sd = 1'b0;
        for (int i = 0; i < 100; i++) begin
            rd(ADDR_COUNTER, rv);
            chk("count bound", 16'h1, {15'h0, rv[14:0] <= 15'h0028});
            if (rv[15] == pv[15] && pv[14:0] > 15'h3 && pv[14:0] < 15'h25) begin
                chk("count step", pv[15] ? pv - 16'h2 : pv + 16'h2, rv);
            end
            su |= rv[15] === 1'b0;
            sd |= rv[15] === 1'b1;
            pv = rv;
        end
        chk("directions", 16'h3, {14'h0, su, sd});
        wr(ADDR_COUNTER, 16'h8010);
        rd(ADDR_COUNTER, rv);
        chk("count write", rv[15] ? 16'h800f : 16'h0011, rv);
        for (int d = 0; d < 2; d++) begin
            wr(ADDR_TRIGCMP, {d[0], 15'h0014});
            wait_trig(n);
            wait_trig(n);
            rd(ADDR_COUNTER, rv);
            chk("dir at trigger", {15'h0, d[0]}, {15'h0, rv[15]});
            chk("count at trigger", 16'h1, {15'h0, d ? (rv[14:0] < 15'h14 && rv[14:0] > 15'hc)
                : (rv[14:0] > 15'h14 && rv[14:0] < 15'h1c)});
        end
        wr(ADDR_TRIGCMP, 16'h0001);
        foreach (ps_tab[i]) begin
            wr(ADDR_UPDCTL, {4'h0, 4'(ps_tab[i]), 8'h00});
            repeat (3) wait_trig(n);
            chk("trigger spacing", 16'(82 * (ps_tab[i] + 1)), 16'(n));
        end
        wr(ADDR_UPDCTL, 16'h0004);
        wr(ADDR_DUTY0, 16'h0014);
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_PAIRCFG, {7'h0, m[0], 8'hff});
            cyc(4);
            chk("pairs 1-3", 16'h0007, {10'h0, pwm_high[3:1], pwm_low[3:1]});
            su = 1'b0;
            for (int i = 0; i < 90; i++) begin
                chk("pair0 low", {15'h0, m ? pwm_high[0] : ~pwm_high[0]}, {15'h0, pwm_low[0]});
                su |= pwm_high[0];
                cyc(1);
            end
            chk("pair0 toggles", 16'h1, {15'h0, su});
        end
        wr(ADDR_PAIRCFG, 16'h00ff);
        for (int t = 0; t < 3; t++) begin
            wr(ADDR_DTTIME, dt_tab[t]);
            wr(ADDR_DTSEL, sel_tab[t]);
            gap_meas(1'b1, g);
            chk("inactive gap", 16'(ina_tab[t]), 16'(g));
            gap_meas(1'b0, g);
            chk("active gap", 16'(act_tab[t]), 16'(g));
        end
        wr(ADDR_DTTIME, 16'h0000);
        wr(ADDR_DUTY0, 16'h0000);
        apply(ADDR_DUTY0, 16'h7fff, 2'b10, 1'b0);
        wr(ADDR_UPDCTL, 16'h0000);
        apply(ADDR_DUTY0, 16'h0000, 2'b01, 1'b1);
        wr(ADDR_UPDCTL, 16'h0005);
        wr(ADDR_DUTY0, 16'h7fff);
        cyc(100);
        pins("update inhibited", 2'b01);
        apply(ADDR_OVERRIDE, 16'hfc02, 2'b10, 1'b0);
        wr(ADDR_UPDCTL, 16'h0002);
        apply(ADDR_OVERRIDE, 16'hfc01, 2'b01, 1'b1);
        wr(ADDR_FAULTA, 16'h0200);
        @(posedge mclk);
        fault_req <= 1'b1;
        cyc(5);
        pins("fault disabled", 2'b01);
        wr(ADDR_FAULTA, 16'h0201);
        cyc(3);
        pins("fault forced", 2'b10);
        fault_req <= 1'b0;
        cyc(100);
        pins("fault latched", 2'b10);
        wr(ADDR_FAULTA, 16'h0201);
        cyc(3);
        pins("latch cleared", 2'b01);
        wr(ADDR_FAULTA, 16'h0281);
        fault_req <= 1'b1;
        cyc(3);
        pins("cycle fault", 2'b10);
        fault_req <= 1'b0;
        cyc(90);
        pins("cycle released", 2'b01);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
